// ### hw/crbc_pkg.sv
// constants for the card reader bus control block
package crbc_pkg;
	localparam int CLK_MHZ = 50;
	localparam int POWER_UP_S = 4;
	localparam int PICK_PULSE_US = 25;
	localparam int PICK_PULSE_CYC = PICK_PULSE_US * CLK_MHZ;
	localparam int POWER_UP_CYC = POWER_UP_S * 1000000 * CLK_MHZ;
	localparam int OFFSET_PULSE_CYC = 1;
	localparam logic [6:0] DEV_CODE = 7'h68;
	// io bus bit numbers, bit 0 is the msb of the 36-bit word
	localparam int BIT_RESET = 23;
	localparam int BIT_OFFSET = 24;
	localparam int BIT_CARD_IN = 24;
	localparam int BIT_READING = 26;
	localparam int BIT_PICK = 26;
	localparam int BIT_FAULT_EN = 27;
	localparam int BIT_CLR_OVR = 28;
	localparam int BIT_READY_EN = 29;
	localparam int BIT_CLR_EOF = 30;
	localparam int BIT_CLR_EOC = 31;
	localparam int BIT_CLR_VALID = 32;
	localparam int BIT_CHAN_HI = 33;
	localparam int BIT_CHAN_LO = 35;
	localparam logic [2:0] CHAN_RESET = 3'h0;
	localparam logic [11:0] COLUMN_RESET = 12'h000;
	// apb register byte addresses
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam int CTRL_SW_CLEAR = 0;
endpackage

// ### hw/crbc_sync.sv
// two flip-flop synchroniser for a group of async inputs
`timescale 1ns/10ps
module crbc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

// ### hw/crbc_top.sv
// card reader bus control: io bus strobes, pick, interrupt and status
// Contract
// - power-up hold clears channel register throughout
// - general clear resets buffer and flags
// - general clear also clears interrupt channel
// - select matches device code octal 150
// - clear strobe with bit 26 sets pick
// - bits 27, 29 load interrupt enables
// - bits 28, 30 clear overrun, file end
// - bits 31, 32 clear card done, valid
// - selected clear strobe zeroes channel register
// - set strobe bit 23 clears control logic
// - set strobe bit 24 sends offset
// - set strobe loads channel from bits 33-35
// - ready to pick: ready and no pick pulse
// - enabled ready term feeds interrupt request
// - request drives decoded channel line only
// - status gated by select, power, control-in
// - status: ready bit 29, channel 33-35
// - pick and ready fire 25us pulse, clears pick
// - at most one interrupt line asserted
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/10ps
module crbc_top #(
	parameter int POWER_UP_CYCLES = crbc_pkg::POWER_UP_CYC,
	parameter int PICK_CYCLES = crbc_pkg::PICK_PULSE_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic power_up_hold,
	input wire logic [6:0] device_select_lines,
	input wire logic cmd_clear_in,
	input wire logic cmd_set_in,
	input wire logic control_in,
	input wire logic io_reset,
	input wire logic [0:35] iob_in,
	output logic [0:35] iob_out,
	output logic iob_out_en,
	output logic [1:7] irq_lines,
	input wire logic reader_ready_line,
	input wire logic fault_line,
	input wire logic card_in_line,
	output logic feed_command_line,
	output logic offset_line,
	output logic [11:0] column_buffer,
	output logic card_reading_flag,
	output logic overrun_flag,
	output logic file_end_flag,
	output logic card_done_flag,
	output logic column_valid_flag
);
	// the pick counter is sixteen bits wide
	if (PICK_CYCLES < 1 || PICK_CYCLES > 65536 || POWER_UP_CYCLES < 1) begin : g_bad_cfg
		$error("crbc_top: cycle counts out of range");
	end

	typedef enum logic [1:0] {CRBC_IDLE, CRBC_PICK, CRBC_WAIT} crbc_pick_t;

	// all outside inputs except the apb port pass two flops first
	localparam int SW = 7 + 1 + 1 + 1 + 1 + 1 + 36 + 1 + 1 + 1;
	logic [SW-1:0] raw_in, sync_in;
	assign raw_in = {device_select_lines, power_up_hold, cmd_clear_in, cmd_set_in, control_in, io_reset,
		iob_in, reader_ready_line, fault_line, card_in_line};
	crbc_sync #(.WIDTH(SW)) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.d(raw_in),
		.q(sync_in)
	);

	logic [6:0] sel_s;
	logic pwr_s, clr_s, set_s, control_in_s, iorst_s, rdy_s, flt_s, cir_s;
	logic [0:35] iob_s;
	assign {sel_s, pwr_s, clr_s, set_s, control_in_s, iorst_s, iob_s, rdy_s, flt_s, cir_s} = sync_in;

	logic clr_d1_q, set_d1_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clr_d1_q <= 1'b0;
			set_d1_q <= 1'b0;
		end else begin
			clr_d1_q <= clr_s;
			set_d1_q <= set_s;
		end
	end

	logic device_selected, cmd_clear_strobe, cmd_clear_strobe_b, cmd_set_strobe, status_read_gate;
	logic sw_clear_q, general_clear;
	assign device_selected = (sel_s == crbc_pkg::DEV_CODE);
	assign cmd_clear_strobe_b = device_selected && clr_s && !clr_d1_q;
	assign cmd_set_strobe = device_selected && set_s && !set_d1_q;
	assign status_read_gate = device_selected && pwr_s && control_in_s;
	// one-shot for the power-up hold, held active while the hold line stays up
	logic [31:0] pwr_cnt_q;
	logic pwr_oneshot;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr_cnt_q <= '0;
		end else if (pwr_s) begin
			pwr_cnt_q <= 32'(POWER_UP_CYCLES);
		end else if (pwr_cnt_q != '0) begin
			pwr_cnt_q <= pwr_cnt_q - 32'd1;
		end
	end
	assign pwr_oneshot = pwr_s || (pwr_cnt_q != '0);

	logic set_reset_req;
	assign set_reset_req = cmd_set_strobe && iob_s[crbc_pkg::BIT_RESET];
	assign general_clear = pwr_oneshot || iorst_s || set_reset_req || sw_clear_q;
	assign cmd_clear_strobe = cmd_clear_strobe_b || general_clear;

	// interrupt channel register
	logic [2:0] chan_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_q <= crbc_pkg::CHAN_RESET;
		end else if (cmd_clear_strobe || pwr_oneshot) begin
			chan_q <= crbc_pkg::CHAN_RESET;
		end else if (cmd_set_strobe) begin
			chan_q <= iob_s[crbc_pkg::BIT_CHAN_HI:crbc_pkg::BIT_CHAN_LO];
		end
	end

	// control flip-flops loaded by the clear strobe
	logic pick_request_flag, fault_irq_enable, ready_irq_enable;
	logic pick_done;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_irq_enable <= 1'b0;
			ready_irq_enable <= 1'b0;
		end else if (general_clear) begin
			fault_irq_enable <= 1'b0;
			ready_irq_enable <= 1'b0;
		end else if (cmd_clear_strobe_b) begin
			fault_irq_enable <= iob_s[crbc_pkg::BIT_FAULT_EN];
			ready_irq_enable <= iob_s[crbc_pkg::BIT_READY_EN];
		end
	end

	// a strobe arriving with the pulse end keeps the pick set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pick_request_flag <= 1'b0;
		end else if (general_clear) begin
			pick_request_flag <= 1'b0;
		end else if (cmd_clear_strobe_b && iob_s[crbc_pkg::BIT_PICK]) begin
			pick_request_flag <= 1'b1;
		end else if (pick_done) begin
			pick_request_flag <= 1'b0;
		end
	end

	// pick pulse sequencer
	crbc_pick_t pick_state_q;
	logic [15:0] pick_cnt_q;
	logic pick_pulse;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pick_state_q <= CRBC_IDLE;
			pick_cnt_q <= '0;
		end else if (general_clear) begin
			pick_state_q <= CRBC_IDLE;
			pick_cnt_q <= '0;
		end else begin
			case (pick_state_q)
				CRBC_IDLE: begin
					if (pick_request_flag && rdy_s) begin
						pick_state_q <= CRBC_PICK;
						pick_cnt_q <= 16'(PICK_CYCLES - 1);
					end
				end
				CRBC_PICK: begin
					if (pick_cnt_q == '0) begin
						pick_state_q <= CRBC_WAIT;
					end else begin
						pick_cnt_q <= pick_cnt_q - 16'd1;
					end
				end
				default: begin
					// one cycle so the cleared pick flag is seen before rearming
					pick_state_q <= CRBC_IDLE;
				end
			endcase
		end
	end
	assign pick_pulse = (pick_state_q == CRBC_PICK);
	assign pick_done = pick_pulse && (pick_cnt_q == '0);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			feed_command_line <= 1'b0;
			offset_line <= 1'b0;
		end else begin
			feed_command_line <= pick_pulse && !general_clear;
			offset_line <= cmd_set_strobe && iob_s[crbc_pkg::BIT_OFFSET] && !set_reset_req;
		end
	end

	// status flags; column path and card events belong to neighbouring logic
	logic cir_d1_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cir_d1_q <= 1'b0;
		end else begin
			cir_d1_q <= cir_s;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			column_buffer <= crbc_pkg::COLUMN_RESET;
			card_reading_flag <= 1'b0;
			column_valid_flag <= 1'b0;
			overrun_flag <= 1'b0;
			file_end_flag <= 1'b0;
		end else if (general_clear) begin
			column_buffer <= crbc_pkg::COLUMN_RESET;
			card_reading_flag <= 1'b0;
			column_valid_flag <= 1'b0;
			overrun_flag <= 1'b0;
			file_end_flag <= 1'b0;
		end else begin
			if (pick_pulse) begin
				card_reading_flag <= 1'b1;
			end else if (cir_d1_q && !cir_s) begin
				card_reading_flag <= 1'b0;
			end
			if (cmd_clear_strobe_b && iob_s[crbc_pkg::BIT_CLR_VALID]) begin
				column_valid_flag <= 1'b0;
			end
			if (cmd_clear_strobe_b && iob_s[crbc_pkg::BIT_CLR_OVR]) begin
				overrun_flag <= 1'b0;
			end
			if (cmd_clear_strobe_b && iob_s[crbc_pkg::BIT_CLR_EOF]) begin
				file_end_flag <= 1'b0;
			end
		end
	end

	// card done: set when the card leaves, set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			card_done_flag <= 1'b0;
		end else if (general_clear) begin
			card_done_flag <= 1'b0;
		end else if (cir_d1_q && !cir_s && card_reading_flag) begin
			card_done_flag <= 1'b1;
		end else if (cmd_clear_strobe_b && iob_s[crbc_pkg::BIT_CLR_EOC]) begin
			card_done_flag <= 1'b0;
		end
	end

	// interrupt request and channel decode
	logic reader_ready_sync, ready_to_pick, ready_irq_term, irq_request;
	assign reader_ready_sync = rdy_s;
	assign ready_to_pick = reader_ready_sync && !pick_pulse;
	assign ready_irq_term = ready_to_pick && ready_irq_enable;
	assign irq_request = ready_irq_term || (flt_s && fault_irq_enable) || column_valid_flag
		|| card_done_flag;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_lines <= '0;
		end else begin
			irq_lines <= '0;
			if (irq_request && chan_q != 3'h0) begin
				irq_lines[chan_q] <= 1'b1;
			end
		end
	end

	// status word toward the processor
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			iob_out <= '0;
			iob_out_en <= 1'b1;
		end else begin
			iob_out <= '0;
			iob_out_en <= !status_read_gate;
			if (status_read_gate) begin
				iob_out[crbc_pkg::BIT_CARD_IN] <= cir_s;
				iob_out[crbc_pkg::BIT_READING] <= card_reading_flag;
				iob_out[crbc_pkg::BIT_READY_EN] <= ready_to_pick;
				iob_out[crbc_pkg::BIT_CLR_VALID] <= column_valid_flag;
				iob_out[crbc_pkg::BIT_CHAN_HI:crbc_pkg::BIT_CHAN_LO] <= chan_q;
			end
		end
	end

	// apb slave, zero wait states
	logic wr_en;
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	// software clear lasts one cycle, same path as the io bus reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_clear_q <= 1'b0;
		end else begin
			sw_clear_q <= wr_en && paddr == crbc_pkg::ADDR_CTRL && pwdata[crbc_pkg::CTRL_SW_CLEAR];
		end
	end
	always_comb begin
		pslverr = 1'b0;
		if (psel && penable && paddr != crbc_pkg::ADDR_CTRL && paddr != crbc_pkg::ADDR_STATUS) begin
			pslverr = 1'b1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			if (paddr == crbc_pkg::ADDR_STATUS) begin
				// only the low six columns fit beside the flags
				prdata <= {
					11'h000,
					chan_q,
					pick_pulse,
					pick_request_flag,
					fault_irq_enable,
					ready_irq_enable,
					irq_request,
					ready_to_pick,
					card_reading_flag,
					overrun_flag,
					file_end_flag,
					card_done_flag,
					column_valid_flag,
					column_buffer[5:0],
					1'b0
				} & 32'h001F_FFFE;
			end else begin
				prdata <= '0;
			end
		end
	end
endmodule

// ### tb/crbc_top_asserts.sv
// port assertions for the card reader bus control
`timescale 1ns/10ps
module crbc_top_asserts #(
	parameter int POWER_UP_CYCLES = 10,
	parameter int PICK_CYCLES = 5
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic power_up_hold,
	input wire logic [6:0] device_select_lines,
	input wire logic control_in,
	input wire logic io_reset,
	input wire logic iob_out_en,
	input wire logic [1:7] irq_lines,
	input wire logic reader_ready_line,
	input wire logic feed_command_line,
	input wire logic offset_line,
	input wire logic [11:0] column_buffer,
	input wire logic column_valid_flag
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	int feed_q;
	// run length of the feed pulse, too long for a repetition
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			feed_q <= 0;
		end else begin
			feed_q <= feed_command_line ? feed_q + 1 : 0;
		end
	end
	sequence s_read;
		(control_in && power_up_hold && device_select_lines == crbc_pkg::DEV_CODE)[*5];
	endsequence
	sequence s_idle;
		(!control_in)[*5];
	endsequence
	a_one_irq: assert property ($onehot0(irq_lines))
		else $error("two irq lines");
	a_feed_len: assert property ($fell(feed_command_line) |-> feed_q == PICK_CYCLES)
		else $error("feed length");
	a_feed_ready: assert property ($rose(feed_command_line) |-> $past(reader_ready_line, 3)
		|| $past(reader_ready_line, 4) || $past(reader_ready_line, 5)) else $error("feed without ready");
	a_status_on: assert property (s_read |-> !iob_out_en)
		else $error("status not gated");
	a_status_off: assert property (s_idle |-> iob_out_en)
		else $error("status driven idle");
	a_offset_one: assert property (offset_line |=> !offset_line)
		else $error("offset too long");
	a_clear_all: assert property (io_reset[*6] |-> irq_lines == 7'h00
		&& column_buffer == 12'h000 && !column_valid_flag) else $error("clear incomplete");
	a_power_chan: assert property (power_up_hold[*6] |-> irq_lines == 7'h00)
		else $error("irq during power up");
endmodule
bind crbc_top crbc_top_asserts #(.POWER_UP_CYCLES(POWER_UP_CYCLES), .PICK_CYCLES(PICK_CYCLES)) u_chk (.*);

// ### tb/crbc_iob_cpu.sv
// processor side of the io bus: control-out and control-in
`timescale 1ns/10ps
module crbc_iob_cpu (
	input wire logic clk,
	output logic [6:0] sel,
	output logic clr,
	output logic set,
	output logic cin,
	output logic [0:35] dat
);
	initial begin
		sel = 7'h00;
		clr = 1'b0;
		set = 1'b0;
		cin = 1'b0;
		dat = 36'h0_0000_0000;
	end
	// data lines scrambled once released, never left at the last value
	task automatic conout(input logic [6:0] code, input logic [0:35] cw, input logic [0:35] sw);
		sel <= code;
		dat <= cw;
		@(posedge clk);
		clr <= 1'b1;
		repeat (5) @(posedge clk);
		clr <= 1'b0;
		dat <= sw;
		repeat (45) @(posedge clk);
		set <= 1'b1;
		repeat (5) @(posedge clk);
		set <= 1'b0;
		dat <= ~sw;
		repeat (2) @(posedge clk);
		sel <= ~code;
		@(posedge clk);
	endtask
	task automatic conin(input logic [6:0] code, input logic on);
		sel <= code;
		cin <= on;
	endtask
endmodule

// ### tb/tb_card_reader_bus_control.sv
// self-checking bench for the card reader bus control
`timescale 1ns/10ps
module tb_card_reader_bus_control;
	localparam int PU = 10;
	localparam int PK = 5;
	localparam logic [6:0] DC = crbc_pkg::DEV_CODE;
	localparam logic [11:0] AS = crbc_pkg::ADDR_STATUS;
	localparam logic [32:0] MA = 33'h1_FFFF_FFFF;
	localparam logic [32:0] MC = 33'h1_001F_F000;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pwr, io_reset, rdy, feed, offs, oe, clr, set, cin;
	logic flt, rdg, ovr, eof, eoc, vld;
	logic [11:0] paddr, colb;
	logic [31:0] pwdata, prdata, lfsr;
	logic [6:0] sel;
	logic [0:35] dat, iob_out;
	logic [1:7] irq;
	logic [32:0] exq[$], mq[$];
	int failures, cmp_count, cyc, feed_n, off_n, f0;
	crbc_top #(.POWER_UP_CYCLES(PU), .PICK_CYCLES(PK)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .power_up_hold(pwr), .device_select_lines(sel), .cmd_clear_in(clr), .cmd_set_in(set),
		.control_in(cin), .io_reset(io_reset), .iob_in(dat), .iob_out(iob_out), .iob_out_en(oe), .irq_lines(irq),
		.reader_ready_line(rdy), .fault_line(flt), .card_in_line(1'b0), .feed_command_line(feed),
		.offset_line(offs), .column_buffer(colb), .card_reading_flag(rdg), .overrun_flag(ovr),
		.file_end_flag(eof), .card_done_flag(eoc), .column_valid_flag(vld));
	crbc_iob_cpu cpu (.clk(pclk), .sel(sel), .clr(clr), .set(set), .cin(cin), .dat(dat));
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic [32:0] st(input logic [2:0] c, input logic [4:0] f);
		return {12'h000, c, 1'b0, f, 12'h000};
	endfunction
	task automatic chk(input string nm, input logic [35:0] got, input logic [35:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic close_out();
		$display("compares %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
		exq.push_back(e);
		mq.push_back(m);
		lfsr = nxt(lfsr);
		apb(1'b0, a, lfsr);
	endtask
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (psel && penable && !pwrite && exq.size() > 0) begin
			chk("read", 36'({pslverr, prdata} & mq.pop_front()), 36'(exq.pop_front()));
		end
		feed_n += int'(feed === 1'b1);
		off_n += int'(offs === 1'b1);
		cyc++;
		if (cyc == 5000) begin
			failures++;
			close_out();
		end
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		pwr = 1'b1;
		io_reset = 1'b0;
		rdy = 1'b0;
		flt = 1'b0;
		lfsr = 32'h1053_4924;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rdy <= 1'b1;
		cpu.conin(DC, 1'b1);
		repeat (6) @(posedge pclk);
		chk("irq", 36'(irq), 36'h0_0000_0000);
		chk("oe", 36'(oe), 36'h0_0000_0000);
		chk("status", 36'({iob_out[29], iob_out[33:35]}), 36'h0_0000_0008);
		cpu.conin(DC ^ 7'h01, 1'b1);
		repeat (6) @(posedge pclk);
		chk("oe", 36'(oe), 36'h0_0000_0001);
		cpu.conin(DC, 1'b0);
		pwr <= 1'b0;
		repeat (PU + 8) @(posedge pclk);
		rd(AS, st(3'h0, 5'h01), MA);
		rd(12'h008, 33'h1_0000_0000, MA);
		for (int c = 1; c < 8; c++) begin
			cpu.conout(DC, 36'h0_0000_01F8, 36'(c));
			chk("irq", 36'(irq), 36'(7'h40 >> (c - 1)));
			rd(AS, st(3'(c), 5'h0F), MC);
		end
		lfsr = nxt(lfsr);
		cpu.conout(DC ^ (lfsr[6:0] | 7'h01), 36'h0_0000_0000, 36'h0_0000_0000);
		chk("irq", 36'(irq), 36'h0_0000_0001);
		io_reset <= 1'b1;
		repeat (8) @(posedge pclk);
		io_reset <= 1'b0;
		repeat (4) @(posedge pclk);
		rd(AS, st(3'h0, 5'h01), MA);
		flt <= 1'b1;
		cpu.conout(DC, 36'h0_0000_0000, 36'h0_0000_0003);
		rd(AS, st(3'h3, 5'h01), MC);
		flt <= 1'b0;
		f0 = feed_n;
		cpu.conout(DC, 36'h0_0000_0240, 36'h0_0000_0002);
		chk("feed", 36'(feed_n - f0), 36'(PK));
		chk("reading", 36'(rdg), 36'h0_0000_0001);
		rd(AS, st(3'h2, 5'h07), MC);
		f0 = off_n;
		cpu.conout(DC, 36'h0_0000_0000, 36'h0_0000_0801);
		chk("offset", 36'(off_n - f0), 36'h0_0000_0001);
		cpu.conout(DC, 36'h0_0000_0140, 36'h0_0000_1005);
		rd(AS, st(3'h0, 5'h01), MC);
		apb(1'b1, crbc_pkg::ADDR_CTRL, 32'h0000_0001);
		repeat (4) @(posedge pclk);
		rd(AS, st(3'h0, 5'h01), MA);
		@(posedge pclk);
		chk("clear", 36'({rdg, ovr, eof, eoc, vld, colb}), 36'h0_0000_0000);
		close_out();
	end
endmodule
